/* File: bench/egs_front_model.sv */
// Front-end model: turning rotor angle and receiver magnitude
`default_nettype none
module egs_front_model (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic [19:0] step,
	input  wire logic [11:0] mag,
	output logic      [19:0] rotor_angle,
	output logic      [11:0] rx_magnitude
);
	timeunit 1ns;
	timeprecision 1ps;
	// Whole model state
	typedef struct packed {
		logic [19:0] angle;
		logic [11:0] mag;
	} egs_front_t;
	egs_front_t st;      // Registered state
	egs_front_t next_st; // Next state
	// Angle advances a fixed step each cycle, wrapping per turn
	always_comb begin
		next_st = st;
		next_st.angle = st.angle + step;
		next_st.mag = mag;
	end
	// Register the state
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign rotor_angle = st.angle;
	assign rx_magnitude = st.mag;
endmodule : egs_front_model
`default_nettype wire

/* File: bench/tb_excitation_gain_status_regs.sv */
// Self-checking bench for the gain status register block
`default_nettype none
module tb_excitation_gain_status_regs import egs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, rstn, read, write, waitrequest;
	logic [9:0]  address, drive;
	logic [31:0] writedata, readdata, q;
	logic [3:0]  byteenable;
	logic [19:0] step, angle, vel;
	logic [11:0] mag, rxm;
	logic [7:0]  gain;
	logic [8:0]  fine;
	int          bad_count, n_compared, cyc, nw;
	egs_regs egs_regs_i (.clock(clock), .rstn(rstn), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .rotor_angle(angle),
		.rx_magnitude(rxm), .excitation_gain_code(gain),
		.drive_current(drive), .rotor_velocity(vel),
		.fine_coil_periods(fine));
	egs_front_model egs_front_model_i (.clock(clock), .rstn(rstn),
		.step(step), .mag(mag), .rotor_angle(angle), .rx_magnitude(rxm));
	// 25 MHz clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// Compare one value, count and report
	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	// One bus cycle, held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [7:0] idx,
		input logic [31:0] d, input logic [3:0] be);
		nw = 0;
		@(posedge clock);
		address <= {idx, 2'b00};
		write <= w;
		read <= !w;
		writedata <= d;
		byteenable <= be;
		// Only the bench timeout ends a wait that never finishes
		do begin
			@(posedge clock);
			nw++;
		end while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	// Read a register and compare
	task automatic rchk(input string nm, input logic [7:0] idx,
		input logic [31:0] e);
		bus(1'b0, idx, 32'h0, 4'hf);
		check(nm, e, q);
		check("read wait edges", 32'h2, nw);
	endtask : rchk
	// Wait for the gain code to move, at most 900 cycles
	task automatic wait_gain(output int n);
		logic [7:0] c;
		c = gain;
		n = 0;
		while (gain === c && n < 900) begin
			@(negedge clock);
			n++;
		end
	endtask : wait_gain
	// Drive current in 0.05 mA units for a code
	function automatic logic [9:0] drive_of(input logic [7:0] c);
		logic [9:0] n;
		n = {4'h0, c[5:0]};
		case (c[7:6])
			2'b00: return 10'h008 + n;
			2'b01: return 10'h048 + (n << 1);
			2'b10: return 10'h0c8 + (n << 2);
			default: return 10'h1c8 + (n << 3);
		endcase
	endfunction : drive_of
	// Reset values and an unmapped place
	task automatic t_reset;
		rchk("gain reset", 8'h00, 32'h0);
		check("drive reset", 32'h8, {22'h0, drive});
		check("fine reset", 32'h40, {23'h0, fine});
		rchk("target reset", 8'h24, 32'h800);
		rchk("filter reset", 8'h20, 32'h4);
		rchk("unmapped", 8'h30, 32'h0);
		$display("test reset done");
	endtask : t_reset
	// Writes to the status word and partial writes change nothing
	task automatic t_readonly;
		bus(1'b1, 8'h00, 32'hffffffff, 4'hf);
		check("write wait edges", 32'h1, nw);
		rchk("gain written", 8'h00, 32'h0);
		bus(1'b1, 8'h24, 32'h123, 4'hc);
		rchk("target partial", 8'h24, 32'h800);
		$display("test readonly done");
	endtask : t_readonly
	// Every legal period count, then an illegal one
	task automatic t_fine;
		logic [31:0] v;
		for (int i = 0; i < 6; i++) begin
			v = 32'h8 << i;
			bus(1'b1, 8'h5f, v, 4'hf);
			rchk("fine reg", 8'h5f, v);
			check("fine port", v, {23'h0, fine});
		end
		bus(1'b1, 8'h5f, 32'h64, 4'hf);
		rchk("fine illegal", 8'h5f, 32'h100);
		$display("test fine done");
	endtask : t_fine
	// Velocity gated by load, then plain and filtered
	task automatic t_velocity;
		@(posedge clock);
		step <= 20'h3;
		repeat (120) @(negedge clock);
		check("velocity unloaded", 32'h0, {12'h0, vel});
		bus(1'b1, 8'h20, 32'h0, 4'hf);
		bus(1'b1, 8'h21, 32'h1, 4'hf);
		repeat (160) @(negedge clock);
		check("velocity", 32'd150, {12'h0, vel});
		rchk("velocity reg", 8'h22, 32'd150);
		bus(1'b1, 8'h20, 32'h3, 4'hf);
		step <= 20'h0;
		repeat (250) @(negedge clock);
		check("filtered", 32'h1, {31'h0, vel > 0 && vel < 150});
		bus(1'b1, 8'h20, 32'h0, 4'hf);
		repeat (60) @(negedge clock);
		check("velocity still", 32'h0, {12'h0, vel});
		$display("test velocity done");
	endtask : t_velocity
	// Gain code steps up, down, and holds at target
	task automatic t_gain;
		int n;
		logic [7:0] c;
		c = gain;
		wait_gain(n);
		check("gain up", {24'h0, c + 8'h1}, {24'h0, gain});
		@(negedge clock);
		check("drive", {22'h0, drive_of(c + 8'h1)}, {22'h0, drive});
		rchk("gain reg", 8'h00, {24'h0, c + 8'h1});
		rchk("drive reg", 8'h23, {22'h0, drive_of(c + 8'h1)});
		@(posedge clock);
		mag <= 12'hfff;
		wait_gain(n);
		check("gain down", {24'h0, c}, {24'h0, gain});
		@(posedge clock);
		mag <= 12'h800;
		wait_gain(n);
		check("gain hold", 32'd900, n);
		$display("test gain done");
	endtask : t_gain
	// Counts and verdict
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish
	// Cut a hang short
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			tally_and_finish;
		end
	end
	// Main sequence
	initial begin
		{rstn, read, write, address, writedata, byteenable} = '0;
		step = '0;
		mag = 12'h100;
		bad_count = 0;
		n_compared = 0;
		cyc = 0;
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		t_reset;
		t_readonly;
		t_fine;
		t_velocity;
		t_gain;
		tally_and_finish;
	end
endmodule : tb_excitation_gain_status_regs
`default_nettype wire

/* File: logic/egs_cfg.svh */
// Offsets, field positions, reset values and timing of the gain status block
`ifndef EGS_CFG_SVH
`define EGS_CFG_SVH

// Register indices; byte address is four times the index
`define EGS_IDX_GAIN      8'h00
`define EGS_IDX_VEL_CTRL  8'h20
`define EGS_IDX_CFG_DONE  8'h21
`define EGS_IDX_VELOCITY  8'h22
`define EGS_IDX_DRIVE     8'h23
`define EGS_IDX_TARGET    8'h24
`define EGS_IDX_FINE      8'h5f

// Field positions
`define EGS_LPF_EN_BIT    0
`define EGS_COEF_LSB      1
`define EGS_RANGE_MSB     7
`define EGS_RANGE_LSB     6

// Reset values
`define EGS_GAIN_RST      8'h00
`define EGS_FINE_RST      9'h040
`define EGS_TARGET_RST    12'h800
`define EGS_COEF_RST      3'h2

// Drive current bases in 0.05 mA units (0.4, 3.6, 10, 22.8 mA)
`define EGS_BASE_R0       10'h008
`define EGS_BASE_R1       10'h048
`define EGS_BASE_R2       10'h0c8
`define EGS_BASE_R3       10'h1c8

// Timing
`define EGS_CLK_MHZ       25
`define EGS_VEL_PERIOD_NS 2000
`define EGS_VEL_CYCLES    ((`EGS_VEL_PERIOD_NS * `EGS_CLK_MHZ) / 1000)
`define EGS_GAIN_TICKS    16

`endif

/* File: logic/egs_pkg.sv */
// Types shared by the gain status block and its velocity engine
`default_nettype none
package egs_pkg;
	// Bus response machine, one-hot
	typedef enum logic [1:0] {
		EGS_BUS_IDLE = 2'b01,
		EGS_BUS_RESP = 2'b10
	} egs_bus_t;

	// Whole state of the register block
	typedef struct packed {
		egs_bus_t    bus;
		logic [31:0] rdata;
		logic [7:0]  code;
		logic [9:0]  drive;
		logic        lpf_en;
		logic [2:0]  coef;
		logic        cfg_done;
		logic [11:0] target;
		logic [8:0]  fine;
		logic [5:0]  div;
		logic [3:0]  refresh_cnt;
	} egs_regs_state_t;

	// Whole state of the velocity engine
	typedef struct packed {
		logic [19:0] prev_angle;
		logic        primed;
		logic [19:0] vel_f;
	} egs_vel_state_t;
endpackage : egs_pkg
`default_nettype wire

/* File: logic/egs_regs.sv */
// Gain status, drive decode, velocity and coil configuration registers
//
// Design decision made here: the Avalon-MM interface to the registers.
`include "egs_cfg.svh"
`default_nettype none
module egs_regs
	import egs_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic [9:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic [19:0] rotor_angle,
	input  wire logic [11:0] rx_magnitude,
	output logic      [7:0]  excitation_gain_code,
	output logic      [9:0]  drive_current,
	output logic      [19:0] rotor_velocity,
	output logic      [8:0]  fine_coil_periods
);
	egs_regs_state_t st;        // Registered state
	egs_regs_state_t next_st;   // Next state
	egs_vel_if       vel ();    // Link to velocity engine
	logic [7:0]      idx;       // Word index of access
	logic            wr_ok;     // Write with both low lanes
	logic            tick;      // Velocity compute strobe
	logic            refresh;   // Gain loop step strobe
	logic [5:0]      n_step;    // Step count within range
	logic [31:0]     rd_mux;    // Read data selection

	assign idx = address[9:2];
	assign wr_ok = write && (byteenable[1:0] == 2'b11);
	assign tick = (st.div == 6'(`EGS_VEL_CYCLES - 1));
	assign refresh = tick && (st.refresh_cnt == 4'(`EGS_GAIN_TICKS - 1));
	assign n_step = st.code[5:0];

	// Read multiplexer; unmapped words read zero
	always_comb begin
		rd_mux = 32'h00000000;
		case (idx)
			`EGS_IDX_GAIN:     rd_mux = {24'h000000, st.code};
			`EGS_IDX_VEL_CTRL: rd_mux = {28'h0000000, st.coef, st.lpf_en};
			`EGS_IDX_CFG_DONE: rd_mux = {31'h00000000, st.cfg_done};
			`EGS_IDX_VELOCITY: rd_mux = {12'h000, vel.velocity};
			`EGS_IDX_DRIVE:    rd_mux = {22'h000000, st.drive};
			`EGS_IDX_TARGET:   rd_mux = {20'h00000, st.target};
			`EGS_IDX_FINE:     rd_mux = {23'h000000, st.fine};
			default:           rd_mux = 32'h00000000;
		endcase
	end

	// Next-state logic for bus, configuration, gain loop and divider
	always_comb begin
		next_st = st;
		// Two-microsecond divider
		if (tick) begin
			next_st.div = 6'h00;
			next_st.refresh_cnt = st.refresh_cnt + 4'h1;
		end else begin
			next_st.div = st.div + 6'h01;
		end
		// Read takes one wait cycle so data comes from a flop
		case (st.bus)
			EGS_BUS_IDLE: begin
				if (read) begin
					next_st.bus = EGS_BUS_RESP;
					next_st.rdata = rd_mux;
				end
			end
			EGS_BUS_RESP: begin
				next_st.bus = EGS_BUS_IDLE;
			end
			default: begin
				next_st.bus = EGS_BUS_IDLE;
			end
		endcase
		// Configuration writes; gain status word has no write path
		if (wr_ok) begin
			case (idx)
				`EGS_IDX_VEL_CTRL: begin
					next_st.lpf_en = writedata[`EGS_LPF_EN_BIT];
					next_st.coef = writedata[`EGS_COEF_LSB +: 3];
				end
				`EGS_IDX_CFG_DONE: begin
					next_st.cfg_done = writedata[0];
				end
				`EGS_IDX_TARGET: begin
					next_st.target = writedata[11:0];
				end
				`EGS_IDX_FINE: begin
					// Only the six legal period counts are taken
					if (writedata[15:0] == 16'h0008 ||
					    writedata[15:0] == 16'h0010 ||
					    writedata[15:0] == 16'h0020 ||
					    writedata[15:0] == 16'h0040 ||
					    writedata[15:0] == 16'h0080 ||
					    writedata[15:0] == 16'h0100) begin
						next_st.fine = writedata[8:0];
					end
				end
				default: begin
					next_st.fine = st.fine;
				end
			endcase
		end
		// Gain loop steps toward the target magnitude once loaded
		if (refresh && st.cfg_done) begin
			if (rx_magnitude < st.target && st.code != 8'hff) begin
				next_st.code = st.code + 8'h01;
			end else if (rx_magnitude > st.target && st.code != 8'h00) begin
				next_st.code = st.code - 8'h01;
			end
		end
		// Decode applied code into drive current, 0.05 mA units
		// Range 11 takes the widest step (8) and the highest base; range 10 steps by 4
		case (st.code[`EGS_RANGE_MSB:`EGS_RANGE_LSB])
			2'b00:   next_st.drive = `EGS_BASE_R0 + {4'h0, n_step};
			2'b01:   next_st.drive = `EGS_BASE_R1 + {3'h0, n_step, 1'b0};
			2'b10:   next_st.drive = `EGS_BASE_R2 + {2'h0, n_step, 2'b00};
			2'b11:   next_st.drive = `EGS_BASE_R3 + {1'b0, n_step, 3'b000};
			default: next_st.drive = `EGS_BASE_R0;
		endcase
	end

	// State register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st.bus <= EGS_BUS_IDLE;
			st.rdata <= 32'h00000000;
			st.code <= `EGS_GAIN_RST;
			st.drive <= `EGS_BASE_R0;
			st.lpf_en <= 1'b0;
			st.coef <= `EGS_COEF_RST;
			st.cfg_done <= 1'b0;
			st.target <= `EGS_TARGET_RST;
			st.fine <= `EGS_FINE_RST;
			st.div <= 6'h00;
			st.refresh_cnt <= 4'h0;
		end else begin
			st <= next_st;
		end
	end

	// Velocity engine link
	assign vel.tick = tick;
	assign vel.run = st.cfg_done;
	assign vel.lpf_en = st.lpf_en;
	assign vel.coef = st.coef;
	assign vel.angle = rotor_angle;

	egs_velocity u_velocity (
		.clock (clock),
		.rstn  (rstn),
		.vel   (vel.core)
	);

	// Outputs
	assign readdata = st.rdata;
	assign waitrequest = read && (st.bus == EGS_BUS_IDLE);
	assign excitation_gain_code = st.code;
	assign drive_current = st.drive;
	assign rotor_velocity = vel.velocity;
	assign fine_coil_periods = st.fine;

	AST_GAIN_RSVD: assert property (@(posedge clock) disable iff (!rstn)
		read && !waitrequest && idx == `EGS_IDX_GAIN
		|-> readdata[31:8] == 24'h000000 && readdata[7:0] == $past(st.code))
		else $error("gain status read not zero-extended code");

	AST_GAIN_RO: assert property (@(posedge clock) disable iff (!rstn)
		write && idx == `EGS_IDX_GAIN && !refresh |=> $stable(st.code))
		else $error("gain status changed by a write");

	AST_GAIN_UP: assert property (@(posedge clock) disable iff (!rstn)
		refresh && st.cfg_done && rx_magnitude < st.target && st.code != 8'hff
		|=> st.code == $past(st.code) + 8'h01)
		else $error("gain did not step up");

	AST_GAIN_DOWN: assert property (@(posedge clock) disable iff (!rstn)
		refresh && st.cfg_done && rx_magnitude > st.target && st.code != 8'h00
		|=> st.code == $past(st.code) - 8'h01)
		else $error("gain did not step down");

	AST_GAIN_IDLE: assert property (@(posedge clock) disable iff (!rstn)
		!refresh |=> $stable(st.code))
		else $error("gain moved outside refresh");

	AST_RANGE_ZERO: assert property (@(posedge clock) disable iff (!rstn)
		st.code[7:6] == 2'b00 |=> drive_current == 10'h008
		+ {4'h0, $past(st.code[5:0])})
		else $error("range 00 decode wrong");

	AST_RANGE_LOW: assert property (@(posedge clock) disable iff (!rstn)
		st.code[7:6] == 2'b01 |=> drive_current == 10'h048
		+ {3'h0, $past(st.code[5:0]), 1'b0})
		else $error("range 01 decode wrong");

	AST_RANGE_HIGH: assert property (@(posedge clock) disable iff (!rstn)
		st.code[7:6] == 2'b11 |=> drive_current == 10'h1c8
		+ {1'b0, $past(st.code[5:0]), 3'b000})
		else $error("range 11 decode wrong");

	AST_RANGE_SPLIT: assert property (@(posedge clock) disable iff (!rstn)
		st.code[7:6] == 2'b10 |=> drive_current == 10'h0c8
		+ {2'h0, $past(st.code[5:0]), 2'b00})
		else $error("range 10 decode wrong");

	AST_VEL_PERIOD: assert property (@(posedge clock) disable iff (!rstn)
		tick |-> ##50 tick)
		else $error("velocity tick not every 50 cycles");

	AST_FINE_LEGAL: assert property (@(posedge clock) disable iff (!rstn)
		st.fine == 9'h008 || st.fine == 9'h010 || st.fine == 9'h020 ||
		st.fine == 9'h040 || st.fine == 9'h080 || st.fine == 9'h100)
		else $error("illegal fine coil period held");

	AST_STATUS_RST: assert property (@(posedge clock) disable iff (!rstn)
		!st.cfg_done |=> $stable(st.code))
		else $error("gain moved before configuration");
endmodule : egs_regs
`default_nettype wire

/* File: logic/egs_vel_if.sv */
// Signals between the register block and the velocity engine
`default_nettype none
interface egs_vel_if;
	logic        tick;     // One-cycle compute strobe
	logic        run;      // Configuration loaded
	logic        lpf_en;   // Low-pass enable
	logic [2:0]  coef;     // Low-pass shift
	logic [19:0] angle;    // Current rotor angle
	logic [19:0] velocity; // Filtered velocity, signed

	modport core (input tick, run, lpf_en, coef, angle, output velocity);
	modport ctrl (output tick, run, lpf_en, coef, angle, input velocity);
endinterface : egs_vel_if
`default_nettype wire

/* File: logic/egs_velocity.sv */
// Rotor velocity from successive angles, with optional low-pass
`include "egs_cfg.svh"
`default_nettype none
module egs_velocity
	import egs_pkg::*;
(
	input  wire logic clock,
	input  wire logic rstn,
	egs_vel_if.core   vel
);
	egs_vel_state_t     st;       // Registered state
	egs_vel_state_t     next_st;  // Next state
	logic signed [19:0] raw;      // Angle step, wraps across a turn
	logic signed [20:0] err;      // Raw minus filtered
	logic signed [20:0] err_sh;   // Error scaled by coefficient

	// Next-state logic: sample angle on each tick while run is high
	always_comb begin
		next_st = st;
		raw = $signed(vel.angle - st.prev_angle);
		err = $signed({raw[19], raw}) - $signed({st.vel_f[19], st.vel_f});
		err_sh = err >>> vel.coef;
		if (vel.tick && vel.run) begin
			next_st.prev_angle = vel.angle;
			next_st.primed = 1'b1;
			if (!st.primed) begin
				// First sample only seeds the history
				next_st.vel_f = 20'h00000;
			end else if (vel.lpf_en) begin
				next_st.vel_f = st.vel_f + err_sh[19:0];
			end else begin
				next_st.vel_f = raw;
			end
		end
		// Unloaded configuration: forget history
		if (!vel.run) begin
			next_st.primed = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign vel.velocity = st.vel_f;

	AST_LPF_BYPASS: assert property (@(posedge clock) disable iff (!rstn)
		vel.tick && vel.run && st.primed && !vel.lpf_en
		|=> st.vel_f == $past(raw))
		else $error("velocity not raw step with filter off");

	AST_VEL_HOLD: assert property (@(posedge clock) disable iff (!rstn)
		!vel.tick |=> $stable(st.vel_f))
		else $error("velocity changed between ticks");
endmodule : egs_velocity
`default_nettype wire
